// ---- rtl/lacs_adapt.sv ----
/*
  Adaptive current scale regulator.
  Assumes one sample strobe per full step with a stable load value.
*/
`include "lacs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lacs_adapt (
  input wire logic clk_in,
  input wire logic rst_in,
  lacs_if.core cfg
);
  import lacs_pkg::*;

  // ----------------------------------------
  // Thresholds
  // ----------------------------------------
  logic [10:0] lower_thr;
  logic [10:0] upper_thr;
  logic [5:0] floor_scale;
  logic [5:0] run_plus;
  logic [5:0] dec_target;
  logic [3:0] step_w;
  logic [5:0] inc_sum;
  logic [4:0] dec_count_reg;
  logic [4:0] dec_limit;
  lacs_scale_t scale_reg;

  assign lower_thr = {7'h00, cfg.lower_load_threshold} << `LACS_SCALE_SHIFT;
  assign upper_thr = ({7'h00, cfg.lower_load_threshold} + {7'h00, cfg.upper_threshold_span}
    + 11'h001) << `LACS_SCALE_SHIFT;
  // Scale code n is (n+1)/32, so the floor fraction works on n+1
  assign run_plus = {1'b0, cfg.run_current_scale} + 6'h01;
  assign floor_scale = (cfg.floor_quarter ? (run_plus >> 2) : (run_plus >> 1)) - 6'h01;
  assign step_w = 4'h1 << cfg.current_step_up;
  assign inc_sum = {1'b0, scale_reg} + {2'h0, step_w};
  assign dec_target = {1'b0, scale_reg} - 6'h01;
  always_comb begin
    case (cfg.decrement_rate)
      2'h0: dec_limit = 5'h1F;
      2'h1: dec_limit = 5'h07;
      2'h2: dec_limit = 5'h01;
      default: dec_limit = 5'h00;
    endcase
  end

  // ----------------------------------------
  // Scale regulation
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scale_reg <= `LACS_RUN_SCALE_RST;
      dec_count_reg <= 5'h00;
    end else if (!cfg.adapt_enable || cfg.lower_load_threshold == 4'h0) begin
      scale_reg <= cfg.run_current_scale;
      dec_count_reg <= 5'h00;
    end else if (scale_reg > cfg.run_current_scale) begin
      scale_reg <= cfg.run_current_scale;
    end else if (cfg.sample) begin
      if ({1'b0, cfg.load_measure_value} < lower_thr) begin
        dec_count_reg <= 5'h00;
        scale_reg <= (inc_sum > run_plus - 6'h01) ? cfg.run_current_scale : inc_sum[4:0];
      end else if ({1'b0, cfg.load_measure_value} >= upper_thr) begin
        if (dec_count_reg >= dec_limit) begin
          dec_count_reg <= 5'h00;
          // Floor wins over run scale only when run is tiny; never go below it
          if (scale_reg != 5'h00 && dec_target >= floor_scale && dec_target[5] == 1'b0) begin
            scale_reg <= dec_target[4:0];
          end
        end else begin
          dec_count_reg <= dec_count_reg + 5'h01;
        end
      end
    end
  end

  assign cfg.actual_current_scale = scale_reg;
endmodule
`default_nettype wire

// ---- rtl/lacs_if.sv ----
/*
  Interface carrying settings from the register file to the adaptive core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface lacs_if;
  import lacs_pkg::*;
  logic [3:0] lower_load_threshold;
  logic [3:0] upper_threshold_span;
  logic [1:0] current_step_up;
  logic [1:0] decrement_rate;
  logic floor_quarter;
  lacs_scale_t run_current_scale;
  logic adapt_enable;
  logic sample;
  lacs_load_t load_measure_value;
  lacs_scale_t actual_current_scale;
  modport ctrl (
    output lower_load_threshold, upper_threshold_span, current_step_up,
    output decrement_rate, floor_quarter, run_current_scale, adapt_enable,
    output sample, load_measure_value,
    input actual_current_scale
  );
  modport core (
    input lower_load_threshold, upper_threshold_span, current_step_up,
    input decrement_rate, floor_quarter, run_current_scale, adapt_enable,
    input sample, load_measure_value,
    output actual_current_scale
  );
endinterface
`default_nettype wire

// ---- rtl/lacs_params.svh ----
/*
  Constants for the load adaptive current and stall block: register offsets,
  field positions, reset values and timing counts.
  Assumes a Wishbone slave with 32-bit data and word-aligned registers.
*/
`ifndef LACS_PARAMS_SVH
`define LACS_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LACS_ADDR_STALL 8'h00
`define LACS_ADDR_ADAPT 8'h04
`define LACS_ADDR_VTHR 8'h08
`define LACS_ADDR_CTRL 8'h0C
`define LACS_ADDR_STATUS 8'h10
`define LACS_ADDR_IRQST 8'h14
`define LACS_ADDR_IRQMSK 8'h18

// ----------------------------------------
// Field positions of the adaptation register
// ----------------------------------------
`define LACS_F_LOWER_LSB 0
`define LACS_F_SPAN_LSB 4
`define LACS_F_STEPUP_LSB 8
`define LACS_F_DECR_LSB 12
`define LACS_F_FLOOR_BIT 16

// ----------------------------------------
// Reset values, scaling and timing
// ----------------------------------------
`define LACS_RUN_SCALE_RST 5'h1F
`define LACS_SCALE_SHIFT 5
`define LACS_PULSE_NS 1000
`define LACS_CLK_MHZ 100

`endif

// ---- rtl/lacs_pkg.sv ----
/*
  Types for the load adaptive current and stall block.
  Assumes the params header is included by each design file.
*/
package lacs_pkg;
  typedef logic [9:0] lacs_load_t;
  typedef logic [4:0] lacs_scale_t;
  typedef logic [19:0] lacs_interval_t;
  typedef enum logic [1:0] {
    LACS_IDLE,
    LACS_EVAL,
    LACS_APPLY
  } lacs_state_t;
endpackage

// ---- rtl/lacs_top.sv ----
/*
  Load adaptive current and stall detection block with a Wishbone slave.
  Assumes the load measurement, full step strobe, step interval and chopper
  mode come from logic on the same clock; the strobe is one cycle wide.
*/
`include "lacs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lacs_top #(
  parameter int PULSE_CYCLES = (`LACS_PULSE_NS * `LACS_CLK_MHZ) / 1000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic fullstep_in,
  input wire lacs_pkg::lacs_load_t load_measure_value_in,
  input wire lacs_pkg::lacs_interval_t step_interval_measure_in,
  input wire logic quiet_chopper_in,
  input wire logic step_dir_mode_in,
  output logic diagnostic_output_out,
  output lacs_pkg::lacs_scale_t actual_current_scale_out,
  output logic irq_out
);
  import lacs_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] stall_threshold_reg;
  logic [16:0] adapt_reg;
  lacs_interval_t vthr_reg;
  lacs_scale_t run_scale_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  lacs_load_t load_reg;
  logic sample_reg;
  logic [15:0] pulse_cnt_reg;
  logic velocity_ok;
  logic stall_hit;
  logic bus_req;
  logic [31:0] rd_next;
  logic [1:0] irq_event;
  lacs_scale_t scale_prev_reg;
  lacs_if cfg_bus();

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign velocity_ok = vthr_reg >= step_interval_measure_in;

  // ----------------------------------------
  // Load sampling, once per full step
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      load_reg <= 10'h000;
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= fullstep_in;
      if (fullstep_in) begin
        load_reg <= load_measure_value_in;
      end
    end
  end

  // ----------------------------------------
  // Stall detection
  // ----------------------------------------
  assign stall_hit = sample_reg && quiet_chopper_in && velocity_ok
    && ({1'b0, load_reg} < {2'h0, stall_threshold_reg, 1'b0});

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulse_cnt_reg <= 16'h0000;
      diagnostic_output_out <= 1'b0;
    end else if (stall_hit) begin
      // Fixed pulse width so a slow controller still catches a single event
      pulse_cnt_reg <= 16'(PULSE_CYCLES - 1);
      diagnostic_output_out <= 1'b1;
    end else if (pulse_cnt_reg != 16'h0000) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end else begin
      diagnostic_output_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Adaptive core
  // ----------------------------------------
  assign cfg_bus.lower_load_threshold = adapt_reg[`LACS_F_LOWER_LSB +: 4];
  assign cfg_bus.upper_threshold_span = adapt_reg[`LACS_F_SPAN_LSB +: 4];
  assign cfg_bus.current_step_up = adapt_reg[`LACS_F_STEPUP_LSB +: 2];
  assign cfg_bus.decrement_rate = adapt_reg[`LACS_F_DECR_LSB +: 2];
  assign cfg_bus.floor_quarter = adapt_reg[`LACS_F_FLOOR_BIT];
  assign cfg_bus.run_current_scale = run_scale_reg;
  assign cfg_bus.adapt_enable = velocity_ok && !step_dir_mode_in;
  assign cfg_bus.sample = sample_reg;
  assign cfg_bus.load_measure_value = load_reg;

  lacs_adapt u_adapt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cfg(cfg_bus)
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      actual_current_scale_out <= `LACS_RUN_SCALE_RST;
      scale_prev_reg <= `LACS_RUN_SCALE_RST;
    end else begin
      actual_current_scale_out <= cfg_bus.actual_current_scale;
      scale_prev_reg <= cfg_bus.actual_current_scale;
    end
  end

  // ----------------------------------------
  // Interrupts: bit 0 stall, bit 1 scale change
  // ----------------------------------------
  assign irq_event = {scale_prev_reg != cfg_bus.actual_current_scale, stall_hit};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status_reg <= 2'h0;
    end else if (bus_req && !wb_we_in && wb_adr_in == `LACS_ADDR_IRQST) begin
      // Event in the clearing cycle is kept
      irq_status_reg <= irq_event;
    end else begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Wishbone register writes
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stall_threshold_reg <= 8'h00;
      adapt_reg <= 17'h00000;
      vthr_reg <= 20'h00000;
      run_scale_reg <= `LACS_RUN_SCALE_RST;
      irq_mask_reg <= 2'h0;
    end else if (bus_req && wb_we_in) begin
      case (wb_adr_in)
        `LACS_ADDR_STALL: begin
          if (wb_sel_in[0]) stall_threshold_reg <= wb_dat_in[7:0];
        end
        `LACS_ADDR_ADAPT: begin
          if (wb_sel_in[0]) adapt_reg[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1]) adapt_reg[15:8] <= wb_dat_in[15:8];
          if (wb_sel_in[2]) adapt_reg[16] <= wb_dat_in[16];
        end
        `LACS_ADDR_VTHR: begin
          if (wb_sel_in[0]) vthr_reg[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1]) vthr_reg[15:8] <= wb_dat_in[15:8];
          if (wb_sel_in[2]) vthr_reg[19:16] <= wb_dat_in[19:16];
        end
        `LACS_ADDR_CTRL: begin
          if (wb_sel_in[0]) run_scale_reg <= wb_dat_in[4:0];
        end
        `LACS_ADDR_IRQMSK: begin
          if (wb_sel_in[0]) irq_mask_reg <= wb_dat_in[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Wishbone reads and acknowledge
  // ----------------------------------------
  always_comb begin
    case (wb_adr_in)
      `LACS_ADDR_STALL: rd_next = {24'h000000, stall_threshold_reg};
      `LACS_ADDR_ADAPT: rd_next = {15'h0000, adapt_reg};
      `LACS_ADDR_VTHR: rd_next = {12'h000, vthr_reg};
      `LACS_ADDR_CTRL: rd_next = {27'h0000000, run_scale_reg};
      `LACS_ADDR_STATUS: rd_next = {6'h00, load_reg, 11'h000, cfg_bus.actual_current_scale};
      `LACS_ADDR_IRQST: rd_next = {30'h00000000, irq_status_reg};
      `LACS_ADDR_IRQMSK: rd_next = {30'h00000000, irq_mask_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        wb_dat_out <= rd_next;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/lacs_ctrl_model.sv ----
/*
  Motion controller model: issues full steps with a load value, halts on stall.
  Assumes one request pulse per step, on the block clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lacs_ctrl_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire lacs_pkg::lacs_load_t req_load_in,
  input wire logic halt_en_in,
  input wire logic diagnostic_output_in,
  output logic fullstep_out,
  output lacs_pkg::lacs_load_t load_out,
  output logic stopped_out
);
  import lacs_pkg::*;
  // ----------------------------------------
  // Step issue and stop
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fullstep_out <= 1'b0;
      load_out <= 10'h000;
      stopped_out <= 1'b0;
    end else begin
      fullstep_out <= req_in && !stopped_out;
      // Stale load after the step shows its inverse, not the old value
      if (req_in && !stopped_out) load_out <= req_load_in;
      else if (fullstep_out) load_out <= ~load_out;
      if (!halt_en_in) stopped_out <= 1'b0;
      else if (diagnostic_output_in) stopped_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/lacs_top_properties.sv ----
/*
  Port-level checker for lacs_top.
  Assumes the bench writes registers with all byte lanes enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module lacs_top_properties #(
  parameter int PULSE_CYCLES = 100
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic fullstep_in,
  input wire lacs_pkg::lacs_load_t load_measure_value_in,
  input wire lacs_pkg::lacs_interval_t step_interval_measure_in,
  input wire logic quiet_chopper_in,
  input wire logic step_dir_mode_in,
  input wire logic diagnostic_output_out,
  input wire lacs_pkg::lacs_scale_t actual_current_scale_out,
  input wire logic irq_out
);
  import lacs_pkg::*;
  // ----------------------------------------
  // Register shadows and properties
  // ----------------------------------------
  // Retriggered pulses are not modelled; the bench spaces its steps
  localparam int PW = PULSE_CYCLES - 1;
  logic [7:0] thr_q;
  logic [19:0] vthr_q;
  logic [3:0] low_q;
  lacs_scale_t run_q;
  logic mask_q;
  wire logic wr_ok = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in == 4'hF;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_q <= 5'h1F;
      mask_q <= 1'b0;
      low_q <= 4'h0;
    end else if (wr_ok) begin
      if (wb_adr_in == 8'h00) thr_q <= wb_dat_in[7:0];
      if (wb_adr_in == 8'h04) low_q <= wb_dat_in[3:0];
      if (wb_adr_in == 8'h08) vthr_q <= wb_dat_in[19:0];
      if (wb_adr_in == 8'h0C) run_q <= wb_dat_in[4:0];
      if (wb_adr_in == 8'h18) mask_q <= wb_dat_in[0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_step;
    fullstep_in && quiet_chopper_in && vthr_q >= step_interval_measure_in;
  endsequence
  sequence s_stall;
    s_step ##0 load_measure_value_in < {1'b0, thr_q, 1'b0};
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_reset_values: assert property ($fell(rst_in) |-> actual_current_scale_out == 5'h1F
    && !irq_out && !diagnostic_output_out && !wb_ack_out)
    else $error("outputs wrong after reset");
  a_stall_pulse: assert property (s_stall |-> ##[2:3] diagnostic_output_out)
    else $error("stall pulse missing");
  a_stall_block: assert property (fullstep_in && (!quiet_chopper_in
    || vthr_q < step_interval_measure_in || load_measure_value_in >= {1'b0, thr_q, 1'b0})
    |-> ##1 (!$rose(diagnostic_output_out))[*3])
    else $error("stall pulse without cause");
  a_diagnostic_output_width: assert property ($rose(diagnostic_output_out) |-> ##PW diagnostic_output_out
    ##1 !diagnostic_output_out)
    else $error("stall pulse width wrong");
  a_run_follow: assert property (((step_dir_mode_in || low_q == 4'h0) && $stable(run_q))[*3]
    |-> actual_current_scale_out == run_q)
    else $error("scale not at run value while adaptation off");
  a_scale_ceiling: assert property (($stable(run_q))[*3] |-> actual_current_scale_out <= run_q)
    else $error("scale above run value");
  a_irq_stall: assert property (mask_q && $rose(diagnostic_output_out) |-> ##[0:2] irq_out)
    else $error("unmasked stall gave no interrupt");
endmodule
`default_nettype wire

// ---- testbench/load_adaptive_current_stall_test.sv ----
/*
  Self-checking bench for lacs_top: register reads are checked from a queue.
  Assumes the registered Wishbone acknowledge and register map of lacs_top.
*/
`timescale 1ns/1ps
`default_nettype none
module load_adaptive_current_stall_test;
  import lacs_pkg::*;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic clk_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0, quiet = 0, sdm = 1, req = 0, halt = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat;
  lacs_load_t rload = 0, ld;
  lacs_interval_t ivl = 0;
  lacs_scale_t scale;
  logic ack, fs, diagnostic_output, irq, stopped;
  logic [63:0] e;
  logic [63:0] expq[$];
  logic [16:0] seed = 17'h127DF;
  int error_cnt = 0, n_compared = 0, ex, nd[4] = '{32, 8, 2, 1};
  always #5 clk_in = ~clk_in;
  lacs_top #(.PULSE_CYCLES(2)) lacs_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .fullstep_in(fs),
    .load_measure_value_in(ld), .step_interval_measure_in(ivl), .quiet_chopper_in(quiet),
    .step_dir_mode_in(sdm), .diagnostic_output_out(diagnostic_output), .actual_current_scale_out(scale),
    .irq_out(irq));
  lacs_ctrl_model lacs_ctrl_model_inst (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .req_load_in(rload), .halt_en_in(halt), .diagnostic_output_in(diagnostic_output), .fullstep_out(fs),
    .load_out(ld), .stopped_out(stopped));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_in);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    // Request stands until the rising edge that samples ack high
    do begin
      @(posedge clk_in);
      i++;
    end while (ack !== 1'b1 && i < 20);
    {cyc, stb} <= 2'b00;
    if (i >= 20) begin
      error_cnt++;
      close_out();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    expq.push_back({m, x});
    bus(1'b0, a, 32'h0);
  endtask
  task set(input logic q, input lacs_interval_t iv, input logic sd, input logic h);
    @(posedge clk_in);
    {quiet, ivl, sdm, halt} <= {q, iv, sd, h};
  endtask
  task step(input lacs_load_t l);
    @(posedge clk_in);
    {req, rload} <= {1'b1, l};
    @(posedge clk_in);
    req <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  function automatic lacs_load_t rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return lacs_load_t'(17'h00060 + seed % 17'h003A0);
  endfunction
  function automatic logic [31:0] cfg(input int su, input int dn, input int fq);
    return 32'(2 | (su << 8) | (dn << 12) | (fq << 16));
  endfunction
  always @(posedge clk_in) begin
    if (ack && cyc && !we) begin
      if (expq.size() == 0) chk(rdat, 32'hFFFFFFFF);
      else begin
        e = expq.pop_front();
        chk(rdat & e[63:32], e[31:0]);
      end
    end
  end
  task sv(input logic q, input lacs_interval_t iv, input lacs_load_t l, input logic x);
    set(q, iv, 1'b0, 1'b0);
    step(l);
    rd(8'h14, {31'h0, x}, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h0C, 32'h1F, 32'h1F);
    rd(8'h10, 32'h1F, 32'h1F);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    bus(1, 8'h00, 32'h20);
    bus(1, 8'h08, 32'h100);
    bus(1, 8'h18, 32'h1);
    bus(1, 8'h0C, 32'hF);
    bus(1, 8'h04, cfg(0, 3, 0));
    set(1, 20'h00080, 1, 0);
    step(10'h0C8);
    rd(8'h10, 32'hF, 32'h1F);
    set(1, 20'h00080, 0, 0);
    bus(1, 8'h04, 32'h0);
    step(10'h0C8);
    rd(8'h10, 32'hF, 32'h1F);
    bus(1, 8'h04, cfg(0, 0, 0));
    step(10'h00A);
    for (int dn = 0; dn < 4; dn++) begin
      bus(1, 8'h04, cfg(0, dn, 0));
      for (int i = 0; i < nd[dn] - 1; i++) step(i == 0 ? 10'h060 : rnd());
      rd(8'h10, 32'hF, 32'h1F);
      step(rnd());
      rd(8'h10, 32'hE, 32'h1F);
      step(10'h03F);
      rd(8'h10, 32'hF, 32'h1F);
    end
    bus(1, 8'h04, cfg(0, 3, 0));
    repeat (12) step(rnd());
    rd(8'h10, 32'h7, 32'h1F);
    bus(1, 8'h04, cfg(0, 3, 1));
    repeat (6) step(rnd());
    rd(8'h10, 32'h3, 32'h1F);
    ex = 3;
    for (int su = 0; su < 4; su++) begin
      bus(1, 8'h04, cfg(su, 3, 1));
      step(10'h00A);
      ex = (ex + (1 << su) > 15) ? 15 : ex + (1 << su);
      rd(8'h10, 32'(ex), 32'h1F);
      chk(scale, ex);
    end
    step(rnd());
    rd(8'h10, 32'hE, 32'h1F);
    set(1, 20'h00101, 0, 0);
    step(rnd());
    rd(8'h10, 32'hF, 32'h1F);
    rd(8'h14, 32'h3, 32'h3);
    set(1, 20'h00100, 0, 1);
    step(10'h03F);
    chk(irq, 1);
    chk(stopped, 1);
    rd(8'h14, 32'h1, 32'h1);
    repeat (3) @(posedge clk_in);
    chk(irq, 0);
    sv(1, 20'h00080, 10'h040, 0);
    sv(0, 20'h00080, 10'h00A, 0);
    sv(1, 20'h00101, 10'h00A, 0);
    sv(1, 20'h00100, 10'h00A, 1);
    step(10'h3FF);
    rd(8'h10, 32'h03FF0000, 32'h03FF0000);
    repeat (20) @(posedge clk_in);
    rd(8'h10, 32'h03FF0000, 32'h03FF0000);
    bus(1, 8'h18, 32'h0);
    step(10'h00A);
    chk(irq, 0);
    rd(8'h14, 32'h1, 32'h1);
    // Span of one lifts the upper threshold to 128
    bus(1, 8'h04, cfg(0, 3, 0) | 32'h10);
    step(10'h07F);
    rd(8'h10, 32'hF, 32'h1F);
    step(10'h080);
    rd(8'h10, 32'hE, 32'h1F);
    close_out();
  end
endmodule
bind lacs_top lacs_top_properties #(.PULSE_CYCLES(PULSE_CYCLES)) lacs_top_properties_inst (
  .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .fullstep_in(fullstep_in),
  .load_measure_value_in(load_measure_value_in), .quiet_chopper_in(quiet_chopper_in),
  .step_interval_measure_in(step_interval_measure_in), .step_dir_mode_in(step_dir_mode_in),
  .diagnostic_output_out(diagnostic_output_out), .irq_out(irq_out),
  .actual_current_scale_out(actual_current_scale_out));
`default_nettype wire
